/* File: rtl/osmg_pkg.sv */
package osmg_pkg;
   // special function register address of the programming control register
   localparam logic [7:0] CTRL_ADDR = 8'hDC;
   // field positions
   localparam int unsigned BIT_VPRES = 4;
   localparam int unsigned BIT_SIG = 2;
   localparam int unsigned BIT_WE = 1;
   localparam int unsigned BIT_ISM = 0;
   // writable bits; reserved bits and the voltage flag are not stored
   localparam logic [7:0] CTRL_WMASK = 8'h07;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   // signature space depth (address bits used) and byte addresses
   localparam int unsigned SIG_AW = 8;
   localparam logic [7:0] SIG_ADDR0 = 8'h30;
   localparam logic [7:0] SIG_ADDR1 = 8'h31;
   localparam logic [7:0] SIG_ADDR2 = 8'h60;
   // cycles a forced power-on reset is held
   localparam int unsigned POR_HOLD_CYC = 16;
endpackage : osmg_pkg

/* File: rtl/osmg_sig_if.sv */
interface osmg_sig_if;
   logic [7:0] addr;
   logic [7:0] data;
   modport rom_side (input addr, output data);
   modport user_side (output addr, input data);
endinterface : osmg_sig_if

/* File: rtl/osmg_sig_rom.sv */
// read-only signature store: no write path exists, so contents can never change
module osmg_sig_rom #(
   parameter logic [7:0] SIG_BYTE0 = 8'hA5, // arbitrary identity value
   parameter logic [7:0] SIG_BYTE1 = 8'h5A, // arbitrary identity value
   parameter logic [7:0] SIG_BYTE2 = 8'h00
) (
   osmg_sig_if.rom_side sig
);
   always_comb begin
      case (sig.addr)
         osmg_pkg::SIG_ADDR0: sig.data = SIG_BYTE0;
         osmg_pkg::SIG_ADDR1: sig.data = SIG_BYTE1;
         osmg_pkg::SIG_ADDR2: sig.data = SIG_BYTE2;
         default: sig.data = 8'hFF;
      endcase
   end
endmodule : osmg_sig_rom

/* File: rtl/osmg_guard.sv */
// Summary of operation
// (R1) With signature select set, reads return the signature byte at the address.
// (R2) Software must not pulse a program write while signature select is high.
// (R3) Signature bytes never change, even on a forbidden write pulse.
// (R4) Transparent mode exists only for parallel and in-system programming.
// (R5) Start-up code must set the in-system mode flag in the control register.
// (R6) With mode flag set, port 1 patterns cannot enter transparent mode.
// (R7) Program voltage on the reset-enable pin forces a power-on reset.
// (R8) Control bits: 4 voltage present (RO), 2 signature select, 1 write enable, 0 mode.
module osmg_guard #(
   parameter logic [7:0] SIG_BYTE0 = 8'hA5, // arbitrary identity value
   parameter logic [7:0] SIG_BYTE1 = 8'h5A  // arbitrary identity value
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   // special function register port
   input wire logic [7:0] sfr_addr_i,
   input wire logic [7:0] sfr_wdata_i,
   input wire logic sfr_wr_i,
   input wire logic sfr_rd_i,
   output logic [7:0] sfr_rdata_o,
   // program memory access
   input wire logic [12:0] mem_addr_i,
   input wire logic [7:0] mem_rdata_i,
   input wire logic mem_rd_i,
   input wire logic prog_pulse_i,
   output logic [7:0] mem_rdata_o,
   output logic prog_pulse_o,
   // pins and mode detection
   input wire logic program_voltage_pin_i,
   input wire logic por_enable_pin_i,
   input wire logic p1_transparent_pattern_i,
   output logic transparent_mode_o,
   output logic por_reset_o
);
   logic [2:0] ctrl;
   logic [1:0] vpp_sync;
   logic [1:0] pore_sync;
   logic [4:0] por_cnt;
   logic vpp_seen;
   logic [5:0] por_len;
   osmg_sig_if sig ();

   // one place for the register decode, shared by the write and read paths
   function automatic logic ctrl_hit(input logic [7:0] addr);
      return addr == osmg_pkg::CTRL_ADDR;
   endfunction : ctrl_hit

   // reference table for the signature checks, kept apart from the store
   function automatic logic [7:0] sig_expect(input logic [7:0] addr);
      case (addr)
         osmg_pkg::SIG_ADDR0: return SIG_BYTE0;
         osmg_pkg::SIG_ADDR1: return SIG_BYTE1;
         osmg_pkg::SIG_ADDR2: return 8'h00;
         default: return 8'hFF;
      endcase
   endfunction : sig_expect

   osmg_sig_rom #(
      .SIG_BYTE0(SIG_BYTE0),
      .SIG_BYTE1(SIG_BYTE1),
      .SIG_BYTE2(8'h00)
   ) u_rom (
      .sig(sig)
   );

   assign sig.addr = mem_addr_i[7:0];

   wire signature_select = ctrl[osmg_pkg::BIT_SIG];
   wire write_enable = ctrl[osmg_pkg::BIT_WE];
   wire insystem_mode_flag = ctrl[osmg_pkg::BIT_ISM];
   wire program_voltage_present = vpp_sync[1];
   wire por_enable_pin = pore_sync[1];

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         vpp_sync <= 2'h0;
         pore_sync <= 2'h0;
      end else begin
         vpp_sync <= {vpp_sync[0], program_voltage_pin_i};
         pore_sync <= {pore_sync[0], por_enable_pin_i};
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         ctrl <= osmg_pkg::CTRL_RESET[2:0];
      end else if (sfr_wr_i && ctrl_hit(sfr_addr_i)) begin
         ctrl <= sfr_wdata_i[2:0] & osmg_pkg::CTRL_WMASK[2:0]; // [R8]
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         sfr_rdata_o <= 8'h00;
      end else if (sfr_rd_i && ctrl_hit(sfr_addr_i)) begin
         // reserved bits read zero; voltage flag is status only
         sfr_rdata_o <= {3'h0, program_voltage_present, 1'b0, ctrl}; // [R8]
      end else begin
         sfr_rdata_o <= 8'h00;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         mem_rdata_o <= 8'h00;
      end else if (mem_rd_i) begin
         mem_rdata_o <= signature_select ? sig.data : mem_rdata_i; // [R1]
      end
   end

   // the pulse is dropped while the signature space is selected, so the
   // protected bytes stay intact whatever software does
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         prog_pulse_o <= 1'b0;
      end else begin
         prog_pulse_o <= prog_pulse_i && write_enable && !signature_select; // [R3] [R8]
      end
   end

   // port 1 patterns enter transparent mode only while the flag is clear;
   // with voltage present and the flag set the mode is entered on purpose
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         transparent_mode_o <= 1'b0;
      end else if (insystem_mode_flag) begin
         transparent_mode_o <= program_voltage_present; // [R4] [R6]
      end else begin
         transparent_mode_o <= p1_transparent_pattern_i; // [R4]
      end
   end

   // previous voltage state; an edge, not the level, starts the forced reset,
   // so a voltage held for a whole programming session resets only once
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         vpp_seen <= 1'b0;
      end else begin
         vpp_seen <= program_voltage_present;
      end
   end

   // high voltage enables the reset circuit even if the enable pin is low
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         por_cnt <= 5'h00;
         por_reset_o <= 1'b0;
      end else if (program_voltage_present && !vpp_seen && por_cnt == 5'h00
                   && !por_reset_o) begin
         por_cnt <= 5'(osmg_pkg::POR_HOLD_CYC); // [R7]
         por_reset_o <= 1'b1;
      end else if (por_cnt != 5'h00) begin
         por_cnt <= por_cnt - 5'h01;
         por_reset_o <= (por_cnt != 5'h01);
      end else begin
         por_reset_o <= 1'b0;
      end
   end

   wire unused_ok = &{1'b0, por_enable_pin, mem_addr_i[12:8]};

   // assertion helper: length of the current forced reset pulse
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         por_len <= 6'h00;
      end else if (por_reset_o) begin
         por_len <= por_len + 6'h01;
      end else begin
         por_len <= 6'h00;
      end
   end

   // a fresh voltage edge while no forced reset is running
   sequence vpp_arrive_s;
      $rose(program_voltage_present) && por_cnt == 5'h00 && !por_reset_o;
   endsequence
   // first part of the forced reset; the full length is checked by a counter
   sequence por_hold_s;
      por_reset_o [*8];
   endsequence

   sig_read_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R1]
      mem_rd_i && signature_select |=> mem_rdata_o == $past(sig.data))
      else $error("signature read wrong");
   sig_value_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R1]
      mem_rd_i && signature_select |=> mem_rdata_o == sig_expect($past(mem_addr_i[7:0])))
      else $error("signature byte differs from table");
   sig_protect_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R3]
      signature_select |=> !prog_pulse_o)
      else $error("write pulse passed with signature select");
   pulse_pass_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R8]
      prog_pulse_i && write_enable && !signature_select |=> prog_pulse_o)
      else $error("enabled write pulse lost");
   we_block_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R8]
      !write_enable |=> !prog_pulse_o)
      else $error("write pulse passed without write enable");
   mode_block_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R6]
      insystem_mode_flag && !program_voltage_present |=> !transparent_mode_o)
      else $error("transparent mode entered despite flag");
   por_force_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R7]
      vpp_arrive_s |=> por_hold_s)
      else $error("forced reset missing");
   por_len_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R7]
      $fell(por_reset_o) |-> por_len == 6'(osmg_pkg::POR_HOLD_CYC))
      else $error("forced reset length wrong");
   por_once_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R7]
      $fell(por_reset_o) && program_voltage_present |=> !por_reset_o)
      else $error("forced reset repeated while voltage held");
   ro_status_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R8]
      sfr_rd_i && ctrl_hit(sfr_addr_i)
      |=> sfr_rdata_o[7:5] == 3'h0 && sfr_rdata_o[4] == $past(program_voltage_present))
      else $error("status read wrong");
   ctrl_write_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R8]
      sfr_wr_i && ctrl_hit(sfr_addr_i) |=> ctrl == $past(sfr_wdata_i[2:0]))
      else $error("control write lost");
   pattern_pass_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R4]
      !insystem_mode_flag |=> transparent_mode_o == $past(p1_transparent_pattern_i))
      else $error("transparent mode not from pattern");
   user_read_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R1]
      mem_rd_i && !signature_select |=> mem_rdata_o == $past(mem_rdata_i))
      else $error("user read wrong");
endmodule : osmg_guard

/* File: verification/osmg_guard_bench.sv */
module osmg_guard_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic sfr_wr_i = 1'b0;
   logic sfr_rd_i = 1'b0;
   logic mem_rd_i = 1'b0;
   logic prog_pulse_i = 1'b0;
   logic vpin = 1'b0;
   logic pen = 1'b1;
   logic pat = 1'b0;
   logic [7:0] sfr_addr_i = 8'h00;
   logic [7:0] sfr_wdata_i = 8'h00;
   logic [7:0] mem_rdata_i = 8'h3C;
   logic [12:0] mem_addr_i = 13'h0000;
   logic [7:0] sfr_rdata_o;
   logic [7:0] mem_rdata_o;
   logic prog_pulse_o;
   logic transparent_mode_o;
   logic por_reset_o;
   int mismatches = 0;
   int tests_run = 0;
   int n;
   // set apart from the design defaults so the override is seen on the bus
   localparam logic [7:0] SIG0 = 8'h96; // arbitrary value
   localparam logic [7:0] SIG1 = 8'h69; // arbitrary value

   osmg_guard #(.SIG_BYTE0(SIG0), .SIG_BYTE1(SIG1)) u_dut (
      .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .sfr_addr_i(sfr_addr_i),
      .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
      .sfr_rdata_o(sfr_rdata_o), .mem_addr_i(mem_addr_i), .mem_rdata_i(mem_rdata_i),
      .mem_rd_i(mem_rd_i), .prog_pulse_i(prog_pulse_i), .mem_rdata_o(mem_rdata_o),
      .prog_pulse_o(prog_pulse_o), .program_voltage_pin_i(vpin), .por_enable_pin_i(pen),
      .p1_transparent_pattern_i(pat), .transparent_mode_o(transparent_mode_o),
      .por_reset_o(por_reset_o));

   initial begin
      forever #5 sys_clk_i = ~sys_clk_i;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // every driver runs 1 ns after a rising edge
   task automatic step;
      @(posedge sys_clk_i);
      #1;
   endtask : step

   task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr_i = a;
      sfr_wdata_i = d;
      sfr_wr_i = 1'b1;
      step();
      sfr_wr_i = 1'b0;
      step();
   endtask : sfr_wr

   task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp);
      sfr_addr_i = a;
      sfr_rd_i = 1'b1;
      step();
      sfr_rd_i = 1'b0;
      chk(sfr_rdata_o, exp);
      step();
   endtask : sfr_rd

   task automatic mem_rd(input logic [12:0] a, input logic [7:0] exp);
      mem_addr_i = a;
      mem_rd_i = 1'b1;
      step();
      mem_rd_i = 1'b0;
      chk(mem_rdata_o, exp);
      step();
   endtask : mem_rd

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : complete_run

   // whole sequence is about 80 cycles; allow over eighteen times that
   initial begin
      #15000;
      mismatches++;
      complete_run();
   end

   initial begin
      repeat (20) @(posedge sys_clk_i);
      #1;
      resetn_i = 1'b1;
      chk({5'h00, prog_pulse_o, transparent_mode_o, por_reset_o}, 8'h00);
      sfr_rd(osmg_pkg::CTRL_ADDR, 8'h00);
      sfr_wr(osmg_pkg::CTRL_ADDR, 8'hFF);
      sfr_rd(osmg_pkg::CTRL_ADDR, 8'h07);
      sfr_wr(8'hDD, 8'h00);
      sfr_rd(osmg_pkg::CTRL_ADDR, 8'h07);
      sfr_rd(8'hDD, 8'h00);
      mem_rd(13'h0030, SIG0);
      mem_rd(13'h0031, SIG1);
      mem_rd(13'h1060, 8'h00);
      mem_rd(13'h0045, 8'hFF);
      // forbidden pulse with signature select high must be dropped
      prog_pulse_i = 1'b1;
      step();
      chk({7'h00, prog_pulse_o}, 8'h00);
      prog_pulse_i = 1'b0;
      mem_rd(13'h0030, SIG0);
      sfr_wr(osmg_pkg::CTRL_ADDR, 8'h03);
      prog_pulse_i = 1'b1;
      step();
      chk({7'h00, prog_pulse_o}, 8'h01);
      prog_pulse_i = 1'b0;
      mem_rd(13'h0030, 8'h3C);
      pat = 1'b1;
      step();
      chk({7'h00, transparent_mode_o}, 8'h00);
      sfr_wr(osmg_pkg::CTRL_ADDR, 8'h00);
      step();
      chk({7'h00, transparent_mode_o}, 8'h01);
      pat = 1'b0;
      sfr_wr(osmg_pkg::CTRL_ADDR, 8'h01);
      // write enable clear: a pulse must be dropped as well
      prog_pulse_i = 1'b1;
      step();
      chk({7'h00, prog_pulse_o}, 8'h00);
      prog_pulse_i = 1'b0;
      // power-on reset disabled at the pin, then program voltage applied
      pen = 1'b0;
      vpin = 1'b1;
      for (int i = 0; i < 10 && por_reset_o !== 1'b1; i++) step();
      n = 0;
      while (por_reset_o === 1'b1 && n < 40) begin
         n++;
         step();
      end
      chk(8'(n), 8'(osmg_pkg::POR_HOLD_CYC));
      chk({7'h00, transparent_mode_o}, 8'h01);
      // voltage still held: the forced reset must not come back
      repeat (4) step();
      chk({7'h00, por_reset_o}, 8'h00);
      sfr_wr(osmg_pkg::CTRL_ADDR, 8'h10);
      sfr_rd(osmg_pkg::CTRL_ADDR, 8'h10);
      vpin = 1'b0;
      complete_run();
   end
endmodule : osmg_guard_bench
